// ### osd_i2c_bus_master.sv
// bus master end: sends the address byte then user bytes, checks acknowledges, stops
// assumes the user keeps to the byte formats of the display write port
`timescale 1ns/1ps
`default_nettype none
module osd_i2c_bus_master (
  input wire logic clk_i,
  input wire logic rst_i,
  osd_i2c_if.host bus,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic cmd_last_i,
  output logic cmd_ready_o,
  output logic busy_o,
  output logic nack_o
);
  import osd_i2c_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_ACK, H_NEXT, H_STOP} hstate_t;

  // ==========================================================
  // sda sampling and quarter-period timer
  logic sda_s1_ff, sda_s2_ff;
  logic [15:0] q_cnt_ff;
  logic [1:0] phase_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {sda_s1_ff, sda_s2_ff} <= 2'h3;
    end else begin
      {sda_s1_ff, sda_s2_ff} <= {bus.sda, sda_s1_ff};
    end
  end

  hstate_t state_ff, nxt_state;
  wire timed = (state_ff != H_IDLE) && (state_ff != H_NEXT);
  wire tick = timed && (q_cnt_ff == SCL_QUARTER_CYC - 16'h1);
  wire take = (state_ff == H_NEXT) && cmd_valid_i && cmd_ready_o;

  always_ff @(posedge clk_i) begin
    if (rst_i || !timed || tick) begin
      q_cnt_ff <= 16'h0;
    end else begin
      q_cnt_ff <= q_cnt_ff + 16'h1;
    end
  end

  // ==========================================================
  // sequencing
  logic [7:0] shift_ff, nxt_shift;
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic last_ff, nxt_last;
  logic nack_ff, nxt_nack;
  logic [1:0] nxt_phase;

  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_last = last_ff;
    nxt_nack = nack_ff;
    nxt_phase = tick ? phase_ff + 2'h1 : phase_ff;
    unique case (state_ff)
      H_IDLE: begin
        if (cmd_valid_i) begin
          nxt_state = H_START;
          nxt_shift = SLAVE_ADDR_BYTE;
          nxt_last = 1'b0;
          nxt_nack = 1'b0;
          nxt_phase = 2'h0;
        end
      end
      H_START: begin
        if (tick && phase_ff == 2'h3) begin
          nxt_state = H_BIT;
          nxt_bit_cnt = 3'h0;
        end
      end
      H_BIT: begin
        if (tick && phase_ff == 2'h3) begin
          nxt_shift = {shift_ff[6:0], 1'b0};
          nxt_bit_cnt = bit_cnt_ff + 3'h1;
          if (bit_cnt_ff == 3'h7) begin
            nxt_state = H_ACK;
          end
        end
      end
      H_ACK: begin
        if (tick && phase_ff == 2'h2) begin
          nxt_nack = sda_s2_ff;
        end
        if (tick && phase_ff == 2'h3) begin
          nxt_state = (nack_ff || last_ff) ? H_STOP : H_NEXT;
        end
      end
      H_NEXT: begin
        // scl is held low while the user has no byte ready
        if (take) begin
          nxt_state = H_BIT;
          nxt_shift = cmd_byte_i;
          nxt_last = cmd_last_i;
          nxt_bit_cnt = 3'h0;
          nxt_phase = 2'h0;
        end
      end
      H_STOP: begin
        if (tick && phase_ff == 2'h3) begin
          nxt_state = H_IDLE;
        end
      end
      // two of the eight state codes are unused; fall back to idle
      default: begin
        nxt_state = H_IDLE;
      end
    endcase
  end

  // ==========================================================
  // wire drive: low during quarters 0 and 3 of each clock
  wire scl_low = (state_ff == H_START) ? (phase_ff == 2'h3) :
                 (state_ff == H_BIT || state_ff == H_ACK) ? (phase_ff == 2'h0 || phase_ff == 2'h3) :
                 (state_ff == H_STOP) ? (phase_ff == 2'h0) :
                 (state_ff == H_NEXT);
  wire sda_low = (state_ff == H_START) ? (phase_ff != 2'h0) :
                 (state_ff == H_BIT) ? ~shift_ff[7] :
                 (state_ff == H_STOP) ? (phase_ff != 2'h3) :
                 (state_ff == H_NEXT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= H_IDLE;
      phase_ff <= 2'h0;
      shift_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      last_ff <= 1'b0;
      nack_ff <= 1'b0;
      bus.scl_host_oe <= 1'b0;
      bus.sda_host_oe <= 1'b0;
      cmd_ready_o <= 1'b0;
      busy_o <= 1'b0;
      nack_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      shift_ff <= nxt_shift;
      bit_cnt_ff <= nxt_bit_cnt;
      last_ff <= nxt_last;
      nack_ff <= nxt_nack;
      bus.scl_host_oe <= scl_low;
      bus.sda_host_oe <= sda_low;
      cmd_ready_o <= (nxt_state == H_NEXT);
      busy_o <= (nxt_state != H_IDLE);
      nack_o <= (state_ff == H_STOP) && (nxt_state == H_IDLE) && nack_ff;
    end
  end

  assign bus.scl_host_o = 1'b0;
  assign bus.sda_host_o = 1'b0;

endmodule : osd_i2c_bus_master
`default_nettype wire

// ### osd_i2c_if.sv
// two-wire bus between the bus master and the display write port
// both wires are open drain with a pull-up resolved here
`timescale 1ns/1ps
`default_nettype none
interface osd_i2c_if;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // ==========================================================
  // wired-and with pull-up
  assign scl = ~(scl_host_oe & ~scl_host_o);
  assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

  modport host (
    output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe,
    input scl, sda
  );
  modport dev (
    output sda_dev_o, sda_dev_oe,
    input scl, sda
  );
endinterface : osd_i2c_if
`default_nettype wire

// ### osd_i2c_pkg.sv
// shared constants and types for the display write port and its bus master
// assumes a 250 MHz system clock on both ends
package osd_i2c_pkg;

  // ==========================================================
  // clock and bus timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SCL_PERIOD_NS = 10000;
  localparam logic [15:0] SCL_QUARTER_CYC = 16'((SCL_PERIOD_NS * 1000) / (4 * CLK_PERIOD_PS));

  // ==========================================================
  // addressing
  // address byte as sent on the wire, write direction included
  localparam logic [7:0] SLAVE_ADDR_BYTE = 8'h7a;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ==========================================================
  // target spaces and layout
  typedef enum logic [1:0] {
    SPACE_DISP,
    SPACE_ATTR,
    SPACE_FONT
  } space_t;

  localparam int FONT_LINES = 18;
  localparam int FONT_DOTS = 12;
  localparam int FONT_UNUSED_BITS = 4;
  localparam logic [5:0] FONT_LAST_COL = 6'h23;
  localparam logic [5:0] REG_LAST_COL = 6'h1f;

  // ==========================================================
  // control register holding the display enable
  localparam logic [3:0] CTRL_ROW = 4'hf;
  localparam logic [5:0] IO_CTRL_COL = 6'h11;
  localparam int DISPLAY_ENABLE_BIT = 7;
  localparam logic DISPLAY_ENABLE_RST = 1'b0;

endpackage : osd_i2c_pkg

// ### osd_i2c_write_port.sv
// display write port: two-wire slave receiver that parses writes into row, column and data
// assumes scl and sda come from another domain; they are synchronised before use
//
// Summary of operation
// - master opens with start, then address byte
// - acknowledge own address during ninth clock
// - each byte is eight bits plus acknowledge
// - master stops on no acknowledge or completion
// - enable display only after all data loaded
// - full format: row, column, then data
// - same row: column then data only
// - continuous: addresses once, rest is data
// - continuous: location advances after each data
// - address msb one is row, zero column
// - column bit six selects continuous format
// - continuous format may not be left
// - glyph is eighteen lines by twelve dots
// - two bytes per line, thirty-six per glyph
// - glyph n sits at row n, columns 0-35
// - row prefix picks display, attribute or font
// - fixed address only, never transmits data
// - display enable bit turns display on
`timescale 1ns/1ps
`default_nettype none
module osd_i2c_write_port (
  input wire logic clk_i,
  input wire logic rst_i,
  osd_i2c_if.dev bus,
  output logic wr_valid_o,
  output osd_i2c_pkg::space_t wr_space_o,
  output logic [3:0] wr_row_o,
  output logic [5:0] wr_col_o,
  output logic [7:0] wr_data_o,
  output logic display_enable_o
);
  import osd_i2c_pkg::*;

  typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA} mode_t;
  typedef enum logic [1:0] {P_ROW, P_ADDR, P_DATA, P_CONT} parse_t;

  // ==========================================================
  // pin synchronisers and condition detect
  logic scl_s1_ff, scl_s2_ff, scl_d_ff;
  logic sda_s1_ff, sda_s2_ff, sda_d_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {scl_s1_ff, scl_s2_ff, scl_d_ff} <= 3'h7;
      {sda_s1_ff, sda_s2_ff, sda_d_ff} <= 3'h7;
    end else begin
      {scl_s1_ff, scl_s2_ff, scl_d_ff} <= {bus.scl, scl_s1_ff, scl_s2_ff};
      {sda_s1_ff, sda_s2_ff, sda_d_ff} <= {bus.sda, sda_s1_ff, sda_s2_ff};
    end
  end

  wire scl_rise = scl_s2_ff & ~scl_d_ff;
  wire scl_fall = ~scl_s2_ff & scl_d_ff;
  wire start_cond = scl_s2_ff & scl_d_ff & ~sda_s2_ff & sda_d_ff;
  wire stop_cond = scl_s2_ff & scl_d_ff & sda_s2_ff & ~sda_d_ff;

  // ==========================================================
  // byte framing and acknowledge
  mode_t mode_ff, nxt_mode;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic ack_phase_ff, nxt_ack_phase;
  logic ack_want_ff, nxt_ack_want;
  logic sda_oe_ff, nxt_sda_oe;
  logic byte_done_ff, nxt_byte_done;

  wire [7:0] rx_byte = {shift_ff[6:0], sda_s2_ff};
  wire last_bit = (bit_cnt_ff == BITS_PER_BYTE - 4'h1);
  // a read request never matches, so the port stays a pure receiver
  wire addr_hit = (rx_byte == SLAVE_ADDR_BYTE);

  always_comb begin
    nxt_mode = mode_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_ack_phase = ack_phase_ff;
    nxt_ack_want = ack_want_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_byte_done = 1'b0;
    if (start_cond) begin
      nxt_mode = M_ADDR;
      nxt_bit_cnt = 4'h0;
      nxt_ack_phase = 1'b0;
      nxt_sda_oe = 1'b0;
    end else if (stop_cond) begin
      nxt_mode = M_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (mode_ff != M_IDLE) begin
      if (scl_rise && bit_cnt_ff < BITS_PER_BYTE) begin
        nxt_shift = rx_byte;
        nxt_bit_cnt = bit_cnt_ff + 4'h1;
        if (last_bit) begin
          nxt_ack_want = (mode_ff == M_DATA) || addr_hit;
          nxt_byte_done = (mode_ff == M_DATA);
          if (mode_ff == M_ADDR) begin
            nxt_mode = addr_hit ? M_DATA : M_IDLE;
          end
        end
      end else if (scl_fall && bit_cnt_ff == BITS_PER_BYTE) begin
        if (!ack_phase_ff) begin
          nxt_ack_phase = 1'b1;
          nxt_sda_oe = ack_want_ff;
        end else begin
          nxt_ack_phase = 1'b0;
          nxt_sda_oe = 1'b0;
          nxt_bit_cnt = 4'h0;
        end
      end
    end
    // a stop inside the acknowledge clock still clears the acknowledge phase at the next falling clock
    if (mode_ff == M_IDLE && !start_cond && scl_fall && ack_phase_ff) begin
      nxt_ack_phase = 1'b0;
      nxt_sda_oe = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= M_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ack_phase_ff <= 1'b0;
      ack_want_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      byte_done_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      ack_phase_ff <= nxt_ack_phase;
      ack_want_ff <= nxt_ack_want;
      sda_oe_ff <= nxt_sda_oe;
      byte_done_ff <= nxt_byte_done;
    end
  end

  assign bus.sda_dev_o = 1'b0;
  assign bus.sda_dev_oe = sda_oe_ff;

  // ==========================================================
  // payload decode
  parse_t parse_ff, nxt_parse;
  space_t cur_space_ff, nxt_space;
  logic [3:0] cur_row_ff, nxt_row;
  logic [5:0] cur_col_ff, nxt_col;
  logic store;

  wire byte_is_row = shift_ff[7];
  wire byte_is_cont = shift_ff[6];
  wire row_is_font = shift_ff[6];
  wire space_t row_space = row_is_font ? SPACE_FONT : (shift_ff[5] ? SPACE_ATTR : SPACE_DISP);
  wire [3:0] row_num = row_is_font ? {1'b0, shift_ff[2:0]} : shift_ff[3:0];
  wire [5:0] col_num = (cur_space_ff == SPACE_FONT) ? shift_ff[5:0] : {1'b0, shift_ff[4:0]};
  wire [5:0] last_col = (cur_space_ff == SPACE_FONT) ? FONT_LAST_COL : REG_LAST_COL;
  wire [3:0] row_mask = (cur_space_ff == SPACE_FONT) ? 4'h7 : 4'hf;
  // font bytes beyond the glyph end have nowhere to go and are dropped
  wire col_in_range = (cur_col_ff <= last_col);
  wire enable_hit = (cur_space_ff == SPACE_ATTR) && (cur_row_ff == CTRL_ROW) && (cur_col_ff == IO_CTRL_COL);

  always_comb begin
    nxt_parse = parse_ff;
    nxt_space = cur_space_ff;
    nxt_row = cur_row_ff;
    nxt_col = cur_col_ff;
    store = 1'b0;
    if (start_cond || stop_cond) begin
      nxt_parse = P_ROW;
    end else if (byte_done_ff) begin
      unique case (parse_ff)
        P_ROW, P_ADDR: begin
          if (byte_is_row) begin
            nxt_space = row_space;
            nxt_row = row_num;
            nxt_parse = P_ADDR;
          end else if (parse_ff == P_ADDR) begin
            nxt_col = col_num;
            nxt_parse = byte_is_cont ? P_CONT : P_DATA;
          end
        end
        P_DATA: begin
          store = 1'b1;
          nxt_parse = P_ADDR;
        end
        P_CONT: begin
          store = 1'b1;
          if (cur_col_ff >= last_col) begin
            nxt_col = 6'h00;
            nxt_row = (cur_row_ff + 4'h1) & row_mask;
          end else begin
            nxt_col = cur_col_ff + 6'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      parse_ff <= P_ROW;
      cur_space_ff <= SPACE_DISP;
      cur_row_ff <= 4'h0;
      cur_col_ff <= 6'h00;
    end else begin
      parse_ff <= nxt_parse;
      cur_space_ff <= nxt_space;
      cur_row_ff <= nxt_row;
      cur_col_ff <= nxt_col;
    end
  end

  // ==========================================================
  // write strobe and display enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_valid_o <= 1'b0;
      wr_space_o <= SPACE_DISP;
      wr_row_o <= 4'h0;
      wr_col_o <= 6'h00;
      wr_data_o <= 8'h00;
      display_enable_o <= DISPLAY_ENABLE_RST;
    end else begin
      wr_valid_o <= store && col_in_range;
      if (store) begin
        wr_space_o <= cur_space_ff;
        wr_row_o <= cur_row_ff;
        wr_col_o <= cur_col_ff;
        wr_data_o <= shift_ff;
      end
      if (store && enable_hit) begin
        display_enable_o <= shift_ff[DISPLAY_ENABLE_BIT];
      end
    end
  end

endmodule : osd_i2c_write_port
`default_nettype wire

// ### osd_i2c_write_port_properties.sv
// checks on the master-to-port link: acknowledge placement, conditions and clock phases
// assumes the link signals arrive as plain inputs, sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module osd_i2c_write_port_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  // ==========================================================
  // helper state: bits since start, open transfer, phase lengths
  logic scl_ff;
  logic sda_ff;
  logic xfer_ff;
  logic [3:0] bits_ff;
  logic [15:0] ack_len_ff;
  logic [15:0] hi_len_ff;
  logic [15:0] lo_len_ff;
  wire start_seen = scl & scl_ff & sda_ff & ~sda;
  wire stop_seen = scl & scl_ff & ~sda_ff & sda;
  wire scl_rise = scl & ~scl_ff;
  wire [3:0] bits_wrap = (bits_ff == 4'h8) ? 4'h0 : bits_ff + 4'h1;
  wire [3:0] nxt_bits = start_seen ? 4'h0 : (scl_rise ? bits_wrap : bits_ff);
  wire nxt_xfer = start_seen | (xfer_ff & ~stop_seen);
  // counts saturate so a long idle never wraps into a short phase
  wire [15:0] nxt_ack_len = sda_dev_oe ? ack_len_ff + {15'h0, ~&ack_len_ff} : 16'h0;
  wire [15:0] nxt_hi_len = scl ? hi_len_ff + {15'h0, ~&hi_len_ff} : 16'h0;
  wire [15:0] nxt_lo_len = scl ? 16'h0 : lo_len_ff + {15'h0, ~&lo_len_ff};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      xfer_ff <= 1'b0;
      bits_ff <= 4'h0;
      ack_len_ff <= 16'h0;
      hi_len_ff <= 16'hffff;
      lo_len_ff <= 16'h0;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
      xfer_ff <= nxt_xfer;
      bits_ff <= nxt_bits;
      ack_len_ff <= nxt_ack_len;
      hi_len_ff <= nxt_hi_len;
      lo_len_ff <= nxt_lo_len;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_after_eighth: assert property ($rose(sda_dev_oe) |-> bits_ff == 4'h8 && !scl)
    else $error("acknowledge not after eighth bit");
  a_ack_ends_ninth: assert property ($fell(sda_dev_oe) |-> bits_ff == 4'h0 && !scl)
    else $error("acknowledge not released after ninth clock");
  a_ack_whole_clock: assert property ($fell(sda_dev_oe) |-> ack_len_ff >= 16'h09ba && ack_len_ff <= 16'h09ce)
    else $error("acknowledge length wrong");
  a_ack_in_transfer: assert property (sda_dev_oe |-> xfer_ff)
    else $error("port drives data line outside a transfer");
  a_start_by_host: assert property (start_seen |-> sda_host_oe && !sda_dev_oe)
    else $error("start not made by master");
  a_stop_after_byte: assert property (stop_seen |-> bits_ff == 4'h1 && !$past(sda_dev_oe))
    else $error("stop not after a whole byte");
  a_high_period: assert property ($fell(scl) |-> hi_len_ff >= 16'h03e8)
    else $error("clock high too short");
  a_low_period: assert property ($rose(scl) |-> lo_len_ff >= 16'h0497)
    else $error("clock low too short");
endmodule : osd_i2c_write_port_properties
`default_nettype wire

// ### test_osd_i2c_write_port.sv
// bench: master and port joined on one link, a bench-driven fast link on a second port
// assumes a 250 MHz clock; the bench link clock runs at 80 ns
`timescale 1ns/1ps
`default_nettype none
module test_osd_i2c_write_port;
  import osd_i2c_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_byte_i = 8'h00;
  logic cmd_last_i = 1'b0;
  logic cmd_ready_o, busy_o, nack_o, wv_a, wv_b, en_a, en_b;
  logic nack_seen = 1'b0;
  space_t sp_a, sp_b;
  logic [3:0] row_a, row_b;
  logic [5:0] col_a, col_b;
  logic [7:0] dat_a, dat_b;
  logic [19:0] got_a[$], got_b[$];
  int failures = 0;
  int comparisons = 0;
  osd_i2c_if bus_a();
  osd_i2c_if bus_b();
  always #2 clk_i = ~clk_i;

  osd_i2c_bus_master osd_i2c_bus_master_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_a.host),
    .cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i), .cmd_last_i(cmd_last_i),
    .cmd_ready_o(cmd_ready_o), .busy_o(busy_o), .nack_o(nack_o));
  osd_i2c_write_port osd_i2c_write_port_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_a.dev), .wr_valid_o(wv_a),
    .wr_space_o(sp_a), .wr_row_o(row_a), .wr_col_o(col_a), .wr_data_o(dat_a), .display_enable_o(en_a));
  osd_i2c_write_port osd_i2c_write_port_inst2 (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_b.dev), .wr_valid_o(wv_b),
    .wr_space_o(sp_b), .wr_row_o(row_b), .wr_col_o(col_b), .wr_data_o(dat_b), .display_enable_o(en_b));
  osd_i2c_write_port_properties osd_i2c_write_port_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
    .sda_host_oe(bus_a.sda_host_oe), .sda_dev_oe(bus_a.sda_dev_oe), .scl(bus_a.scl), .sda(bus_a.sda));

  // ==========================================================
  // monitors and reporting
  always @(posedge clk_i) begin
    if (wv_a === 1'b1) got_a.push_back({sp_a, row_a, col_a, dat_a});
    if (wv_b === 1'b1) got_b.push_back({sp_b, row_b, col_b, dat_b});
    if (nack_o === 1'b1) nack_seen <= 1'b1;
  end

  task automatic chk(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk

  task automatic complete_run;
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  function automatic logic [19:0] w(input space_t s, input logic [3:0] r, input logic [5:0] c, input logic [7:0] d);
    return {s, r, c, d};
  endfunction : w

  task automatic expect_b(input logic [19:0] e);
    logic [19:0] g;
    g = (got_b.size() > 0) ? got_b.pop_front() : 20'hfffff;
    chk(g === e, "stored write differs");
  endtask : expect_b

  // ==========================================================
  // bench link driver: one call is a quarter of a bit
  task automatic qtr(input logic scl_lo, input logic sda_lo);
    bus_b.scl_host_oe <= scl_lo;
    bus_b.sda_host_oe <= sda_lo;
    repeat (5) @(posedge clk_i);
  endtask : qtr

  task automatic start_b;
    qtr(1'b1, 1'b0); qtr(1'b0, 1'b0); qtr(1'b0, 1'b1); qtr(1'b1, 1'b1);
  endtask : start_b

  task automatic stop_b;
    qtr(1'b1, 1'b1); qtr(1'b0, 1'b1); qtr(1'b0, 1'b0);
  endtask : stop_b

  task automatic send(input logic [7:0] b, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      qtr(1'b1, ~b[i]); qtr(1'b0, ~b[i]); qtr(1'b0, ~b[i]); qtr(1'b1, ~b[i]);
    end
    qtr(1'b1, 1'b0); qtr(1'b0, 1'b0);
    chk(bus_b.sda === ~ack, "acknowledge wrong");
    qtr(1'b0, 1'b0); qtr(1'b1, 1'b0);
  endtask : send

  task automatic xfer(input logic [7:0] bs[$]);
    foreach (bs[k]) send(bs[k], 1'b1);
  endtask : xfer

  // master user side: hold the byte until the edge that takes it
  task automatic m_send(input logic [7:0] b, input logic last);
    int n;
    n = 0;
    cmd_valid_i <= 1'b1;
    cmd_byte_i <= b;
    cmd_last_i <= last;
    do begin
      @(posedge clk_i);
      n++;
    end while (cmd_ready_o !== 1'b1 && n < 40000);
    chk(n < 40000, "master took no byte");
  endtask : m_send

  initial begin
    repeat (110000) @(posedge clk_i);
    chk(1'b0, "timeout");
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial begin
    bus_b.scl_host_o = 1'b0;
    bus_b.sda_host_o = 1'b0;
    bus_b.scl_host_oe = 1'b0;
    bus_b.sda_host_oe = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(en_a === 1'b0 && en_b === 1'b0 && busy_o === 1'b0, "state after reset");
    m_send(8'haf, 1'b0);
    m_send(8'h11, 1'b0);
    m_send(8'h80, 1'b1);
    cmd_valid_i <= 1'b0;
    for (int n = 0; n < 40000 && busy_o !== 1'b0; n++) @(posedge clk_i);
    chk(busy_o === 1'b0 && nack_seen === 1'b0 && en_a === 1'b1, "master transfer");
    chk(got_a.size() == 1 && got_a[0] === w(SPACE_ATTR, 4'hf, 6'h11, 8'h80), "master write");
    // foreign and read addresses get no acknowledge, nor do later bytes
    start_b; send(8'h7b, 1'b0); send(8'h80, 1'b0); stop_b;
    start_b; send(8'h78, 1'b0); stop_b;
    start_b;
    xfer('{SLAVE_ADDR_BYTE, 8'h83, 8'h05, 8'h5a, 8'ha2, 8'h1f, 8'h11, 8'h02, 8'h33, 8'hc5, 8'h23, 8'h44,
      8'h63, 8'ha1, 8'h85, 8'h10});
    stop_b;
    expect_b(w(SPACE_DISP, 4'h3, 6'h05, 8'h5a));
    expect_b(w(SPACE_ATTR, 4'h2, 6'h1f, 8'h11));
    expect_b(w(SPACE_ATTR, 4'h2, 6'h02, 8'h33));
    expect_b(w(SPACE_FONT, 4'h5, 6'h23, 8'h44));
    expect_b(w(SPACE_FONT, 4'h5, 6'h23, 8'ha1));
    expect_b(w(SPACE_FONT, 4'h6, 6'h00, 8'h85));
    expect_b(w(SPACE_FONT, 4'h6, 6'h01, 8'h10));
    start_b;
    xfer('{SLAVE_ADDR_BYTE, 8'h9e, 8'h5f, 8'h01, 8'h02});
    // a repeated start drops continuous mode; a column first is ignored
    start_b;
    xfer('{SLAVE_ADDR_BYTE, 8'h03, 8'hff, 8'h24, 8'h99, 8'h00, 8'h12, 8'haf, 8'h11, 8'h80});
    chk(en_b === 1'b1, "display enable not set");
    xfer('{8'h11, 8'h00});
    chk(en_b === 1'b0, "display enable not cleared");
    stop_b;
    expect_b(w(SPACE_DISP, 4'he, 6'h1f, 8'h01));
    expect_b(w(SPACE_DISP, 4'hf, 6'h00, 8'h02));
    expect_b(w(SPACE_FONT, 4'h7, 6'h00, 8'h12));
    expect_b(w(SPACE_ATTR, 4'hf, 6'h11, 8'h80));
    expect_b(w(SPACE_ATTR, 4'hf, 6'h11, 8'h00));
    chk(got_b.size() == 0, "unexpected stored write");
    complete_run();
  end
endmodule : test_osd_i2c_write_port
`default_nettype wire
